// ==== bench/eitu_core_assertions.sv ====
// Concurrent checks on traps and line qualifiers
module eitu_chk (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire last_cycle_i,
  input wire irq_pending_i,
  input wire irq_take_o,
  input wire fetch_i,
  input wire [15:0] fetch_addr_i,
  input wire addr_absent_i,
  input wire single_chip_i,
  input wire [7:0] fetch_byte_o,
  input wire exec_i,
  input wire [7:0] opcode_i,
  input wire opcode_undef_i,
  input wire trap_reset_sel_i,
  input wire soft_trap_o,
  input wire bad_opcode_trap_o,
  input wire fetch_trap_o,
  input wire trap_reset_o,
  input wire abort_o,
  input wire master_irq_enable_i,
  input wire [5:0] line_enable_i,
  input wire [5:0] accept_ok_o,
  input wire port1_bit0_o,
  input wire [5:0] latch_set_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_take; irq_take_o == (last_cycle_i & irq_pending_i); endproperty
  a_take: assert property (p_take) else $error("take");
  property p_ff; ce_i & fetch_i & addr_absent_i & single_chip_i |=> fetch_byte_o == 8'hFF;
  endproperty
  a_ff: assert property (p_ff) else $error("absent fetch");
  property p_soft; ce_i & exec_i & opcode_i == 8'hFF & !opcode_undef_i |=> soft_trap_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft trap");
  property p_bad; ce_i & exec_i & opcode_undef_i |=> bad_opcode_trap_o & abort_o; endproperty
  a_bad: assert property (p_bad) else $error("bad opcode");
  property p_ft;
    ce_i & fetch_i & fetch_addr_i <= 16'h003F & !trap_reset_sel_i |=> fetch_trap_o & abort_o;
  endproperty
  a_ft: assert property (p_ft) else $error("fetch trap");
  property p_tr;
    ce_i & fetch_i & fetch_addr_i[15:7] == 9'h01F & trap_reset_sel_i |=> trap_reset_o & !fetch_trap_o;
  endproperty
  a_tr: assert property (p_tr) else $error("trap reset");
  property p_ok; accept_ok_o == (line_enable_i & {6{master_irq_enable_i}}); endproperty
  a_ok: assert property (p_ok) else $error("accept");
  property p_p0; port1_bit0_o |-> !latch_set_o[0]; endproperty
  a_p0: assert property (p_p0) else $error("pin 0");
  c_soft: cover property (soft_trap_o);
  c_ft: cover property (fetch_trap_o);
  c_tr: cover property (trap_reset_o);
endmodule // eitu_chk
bind eitu_core eitu_chk u_eitu_chk (.*);

// ==== bench/eitu_pins.sv ====
// Board pins feeding the six external interrupt lines
module eitu_pins (
  input wire clk_i,
  output logic [5:0] line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_o = 6'h3F;
  // Move a pin, back again after n cycles when n > 0
  task automatic pulse(input int l, input logic v, input int n);
    @(negedge clk_i);
    line_o[l] = v;
    if (n > 0)
    begin
      repeat (n) @(negedge clk_i);
      line_o[l] = ~v;
    end
  endtask
endmodule // eitu_pins

// ==== bench/test_ext_irq_and_trap_unit.sv ====
// Directed bench for the interrupt and trap unit
module test_ext_irq_and_trap_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rstn_i = 0, ce_i = 1, slow_mode_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic last_cycle_i = 1, irq_pending_i = 1, master_irq_enable_i = 1, fetch_i = 0;
  logic addr_absent_i = 0, single_chip_i = 1, exec_i = 0, opcode_undef_i = 0;
  logic trap_reset_sel_i = 0, accept_i = 0, ret_i = 0, sp_load_i = 0;
  logic port1_bit0_o, irq_take_o, soft_trap_o, bad_opcode_trap_o, fetch_trap_o;
  logic trap_reset_o, abort_o, stack_wr_o, master_irq_enable_o, restore_o;
  logic [3:0] slot_select_i = 4'hF;
  logic [5:0] reg_addr_i = 6'h37, line_enable_i = 6'h3F, latch_set_o, accept_ok_o;
  logic [7:0] reg_wdata_i = 8'h00, opcode_i = 8'h00, status_word_i = 8'h85;
  logic [7:0] reg_rdata_o, fetch_byte_o, stack_wdata_o, status_word_o;
  logic [15:0] fetch_addr_i = 16'h0000, pc_i = 16'h1234, sp_wdata_i = 16'h0100;
  logic [15:0] sp_o, stack_addr_o, pc_o;
  logic [7:0] mem [256];
  wire [5:0] ext_line_i;
  wire [7:0] mem_byte_i = mem[stack_addr_o[7:0]];
  int cnt [6];
  int errors = 0, checked = 0;
  int fe [4] = '{0, 1, 1, 0}, re [4] = '{1, 0, 1, -1};
  int tl [8] = '{0, 0, 5, 5, 2, 2, 1, 1}, tn [8] = '{6, 7, 6, 7, 24, 25, 192, 193};
  eitu_core u_eitu_core (.*);
  eitu_pins u_eitu_pins (.clk_i(clk_i), .line_o(ext_line_i));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (stack_wr_o === 1'b1)
      mem[stack_addr_o[7:0]] <= stack_wdata_o;
    foreach (cnt[i])
      cnt[i] += (latch_set_o[i] === 1'b1);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] d);
    tk(1);
    reg_wdata_i = d;
    reg_wr_i = 1;
    tk(1);
    reg_wr_i = 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    tk(1);
    reg_addr_i = a;
    reg_rd_i = 1;
    tk(1);
    reg_rd_i = 0;
    reg_addr_i = 6'h37;
    chk(reg_rdata_o, e);
  endtask
  task automatic tp(input int l, input logic v, input int n, input int e);
    cnt = '{default: 0};
    u_eitu_pins.pulse(l, v, n);
    tk(230);
    if (e < 0)
      chk(cnt[l] != 0, 1);
    else
      chk(cnt[l], e);
  endtask
  task automatic ft(input logic [15:0] a, input logic ab, input logic s, input logic [2:0] e);
    tk(1);
    fetch_i = 1;
    fetch_addr_i = a;
    addr_absent_i = ab;
    trap_reset_sel_i = s;
    tk(1);
    fetch_i = 0;
    chk({fetch_byte_o === 8'hFF, fetch_trap_o, trap_reset_o}, e);
  endtask
  task automatic ex(input logic [7:0] op, input logic u, input logic [2:0] e);
    tk(1);
    exec_i = 1;
    opcode_i = op;
    opcode_undef_i = u;
    tk(1);
    exec_i = 0;
    opcode_undef_i = 0;
    chk({soft_trap_o, bad_opcode_trap_o, abort_o}, e);
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [1:0] m;
    int k;
    tk(6);
    rstn_i = 1;
    tk(4);
    rd(6'h37, 8'h00);
    chk(port1_bit0_o, 1);
    wr(8'hFF);
    rd(6'h37, 8'hFE);
    rd(6'h38, 8'h00);
    chk(port1_bit0_o, 0);
    ce_i = 0;
    wr(8'h00);
    ce_i = 1;
    rd(6'h37, 8'hFE);
    chk(irq_take_o, 1);
    last_cycle_i = 0;
    tk(1);
    chk(irq_take_o, 0);
    last_cycle_i = 1;
    wr(8'h30);
    tp(4, 1, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i + 3);
      wr({2'h0, m, 4'h0});
      tp(4, 0, 0, fe[m]);
      tp(4, 1, 0, re[m]);
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(e ? 8'h0E : 8'h00);
      for (int l = 1; l < 4; l++)
      begin
        tp(l, 0, 0, e);
        tp(l, 1, 0, 1 - e);
      end
    end
    wr(8'h46);
    for (int i = 0; i < 8; i++)
      tp(tl[i], 0, tn[i], i % 2);
    wr(8'hC6);
    tp(1, 0, 48, 0);
    tp(1, 0, 49, 1);
    slow_mode_i = 1;
    tp(5, 0, 3, 0);
    tp(5, 0, 4, 1);
    slow_mode_i = 0;
    wr(8'h06);
    tp(0, 0, 30, 0);
    slot_select_i = 4'h0;
    tp(2, 0, 30, 0);
    tp(5, 0, 30, 0);
    slot_select_i = 4'hF;
    master_irq_enable_i = 0;
    tk(1);
    chk(accept_ok_o, 6'h00);
    master_irq_enable_i = 1;
    ft(16'h2000, 1, 0, 3'h4);
    ft(16'h0040, 0, 0, 3'h2);
    ft(16'h0F80, 0, 1, 3'h1);
    ex(8'hFF, 0, 3'h4);
    ex(8'h00, 1, 3'h3);
    sp_load_i = 1;
    tk(1);
    sp_load_i = 0;
    accept_i = 1;
    tk(1);
    accept_i = 0;
    tk(6);
    chk(sp_o, 16'h00FD);
    chk({mem[8'hFF], mem[8'hFE]}, 16'h1234);
    mem[8'hFE] = 8'h56;
    ret_i = 1;
    tk(1);
    ret_i = 0;
    for (k = 0; k < 20 && restore_o !== 1'b1; k++)
      tk(1);
    chk(k < 20, 1);
    if (k == 20)
      end_of_test;
    chk(pc_o, 16'h1256);
    chk({status_word_o, 7'h00, master_irq_enable_o}, 16'h8501);
    tk(1);
    chk(sp_o, 16'h0100);
    end_of_test;
  end
endmodule // test_ext_irq_and_trap_unit

// ==== core/eitu_core.v ====
// External interrupt filters, control register and trap unit
`include "eitu_regs.vh"

module eitu_core #(
  parameter [15:0] RAM_HI = 16'h0F7F
) (
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  input wire slow_mode_i,
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input wire [5:0] ext_line_i,
  input wire master_irq_enable_i,
  input wire [5:0] line_enable_i,
  input wire [3:0] slot_select_i,
  output wire [5:0] latch_set_o,
  output wire [5:0] accept_ok_o,
  output wire port1_bit0_o,
  input wire last_cycle_i,
  input wire irq_pending_i,
  output wire irq_take_o,
  input wire fetch_i,
  input wire [15:0] fetch_addr_i,
  input wire [7:0] mem_byte_i,
  input wire addr_absent_i,
  input wire single_chip_i,
  output wire [7:0] fetch_byte_o,
  input wire exec_i,
  input wire [7:0] opcode_i,
  input wire opcode_undef_i,
  input wire trap_reset_sel_i,
  output wire soft_trap_o,
  output wire bad_opcode_trap_o,
  output wire fetch_trap_o,
  output wire trap_reset_o,
  output wire abort_o,
  input wire accept_i,
  input wire [15:0] pc_i,
  input wire [7:0] status_word_i,
  input wire ret_i,
  input wire sp_load_i,
  input wire [15:0] sp_wdata_i,
  output wire [15:0] sp_o,
  output wire [15:0] stack_addr_o,
  output wire stack_wr_o,
  output wire [7:0] stack_wdata_o,
  output wire [15:0] pc_o,
  output wire [7:0] status_word_o,
  output wire master_irq_enable_o,
  output wire restore_o
);

////////////////////////////////////////////////////////////////////////
// Control register

reg [7:0] ctrl_ff;
reg [7:0] rdata_ff;
wire hit = (reg_addr_i == `EITU_CTRL_ADDR);

always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    ctrl_ff <= `EITU_CTRL_RESET;
    rdata_ff <= 8'h00;
  end
  else if (ce_i)
  begin
    if (reg_wr_i && hit)
      ctrl_ff <= {reg_wdata_i[7:1], 1'b0};
    rdata_ff <= (reg_rd_i && hit) ? ctrl_ff : 8'h00;
  end
end

assign reg_rdata_o = rdata_ff;
wire l1_nc = ctrl_ff[`EITU_BIT_L1NC];
wire p0_sel = ctrl_ff[`EITU_BIT_P0SEL];
wire [1:0] l4_es = ctrl_ff[`EITU_BIT_L4ES_HI:`EITU_BIT_L4ES_LO];
// Port use while select is 0, the reset value
assign port1_bit0_o = ~p0_sel;

////////////////////////////////////////////////////////////////////////
// Noise filters

reg [7:0] thr [0:5];
integer k;

always @*
begin
  for (k = 0; k < 6; k = k + 1)
    thr[k] = `EITU_ACC_L234;
  thr[0] = `EITU_ACC_L05;
  thr[5] = `EITU_ACC_L05;
  // New select is used at once, well inside 26 cycles
  thr[1] = l1_nc ? `EITU_ACC_L1_FAST_NC : `EITU_ACC_L1_SLOW_NC;
  if (slow_mode_i)
    for (k = 0; k < 6; k = k + 1)
      thr[k] = `EITU_ACC_SLOWCLK;
end

reg [5:0] sync1_ff;
reg [5:0] sync2_ff;
reg [5:0] flt_ff;
reg [5:0] prev_ff;
reg [7:0] cnt_ff [0:5];
reg [1:0] init_ff;
reg arm4_ff;
wire init_done = (init_ff == 2'h3);

always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    sync1_ff <= 6'h00;
    sync2_ff <= 6'h00;
    init_ff <= 2'h0;
  end
  else if (ce_i)
  begin
    sync1_ff <= ext_line_i;
    sync2_ff <= sync1_ff;
    if (!init_done)
      init_ff <= init_ff + 2'h1;
  end
end

integer j;

// One process drives the filter level, previous level and counters
always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    flt_ff <= 6'h00;
    prev_ff <= 6'h00;
    for (j = 0; j < 6; j = j + 1)
      cnt_ff[j] <= 8'h00;
  end
  else if (ce_i)
  begin
    for (j = 0; j < 6; j = j + 1)
    begin
      prev_ff[j] <= flt_ff[j];
      if (!init_done)
      begin
        // Seed level without producing an edge
        flt_ff[j] <= sync2_ff[j];
        prev_ff[j] <= sync2_ff[j];
        cnt_ff[j] <= 8'h00;
      end
      else if (sync2_ff[j] == flt_ff[j])
        cnt_ff[j] <= 8'h00;
      else if (cnt_ff[j] + 8'h01 >= thr[j])
      begin
        flt_ff[j] <= sync2_ff[j];
        cnt_ff[j] <= 8'h00;
      end
      else
        cnt_ff[j] <= cnt_ff[j] + 8'h01;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Edge selection and latch set

wire [5:0] rise = flt_ff & ~prev_ff;
wire [5:0] fall = ~flt_ff & prev_ff;
reg l4_ev;

always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
    arm4_ff <= 1'b0;
  else if (ce_i && rise[4])
    arm4_ff <= 1'b1;
end

always @*
begin
  case (l4_es)
    `EITU_ES_RISE: l4_ev = rise[4];
    `EITU_ES_FALL: l4_ev = fall[4];
    `EITU_ES_BOTH: l4_ev = rise[4] | fall[4];
    `EITU_ES_HIGH: l4_ev = flt_ff[4] & arm4_ff;
    default: l4_ev = 1'b0;
  endcase
end

wire [5:0] ev;
assign ev[0] = fall[0] & p0_sel;
assign ev[1] = ctrl_ff[`EITU_BIT_L1ES] ? fall[1] : rise[1];
assign ev[2] = (ctrl_ff[`EITU_BIT_L2ES] ? fall[2] : rise[2]) & slot_select_i[0];
assign ev[3] = (ctrl_ff[`EITU_BIT_L3ES] ? fall[3] : rise[3]) & slot_select_i[1];
assign ev[4] = l4_ev & slot_select_i[2];
assign ev[5] = fall[5] & slot_select_i[3];

// Sync plus accept count keeps the latch delay bounded
assign latch_set_o = ev & {6{ce_i}};
assign accept_ok_o = line_enable_i & {6{master_irq_enable_i}};
assign irq_take_o = last_cycle_i & irq_pending_i;

////////////////////////////////////////////////////////////////////////
// Fetch checks and traps

wire in_sfr = (fetch_addr_i <= `EITU_SFR_HI);
wire in_dbr = (fetch_addr_i >= `EITU_DBR_LO) && (fetch_addr_i <= `EITU_DBR_HI);
wire in_ram = (fetch_addr_i >= `EITU_RAM_LO) && (fetch_addr_i <= RAM_HI);
wire bad_area = fetch_i & (in_sfr | in_dbr | in_ram);
reg [7:0] fbyte_ff;
reg soft_ff;
reg undef_ff;
reg ftrap_ff;
reg trst_ff;

always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    fbyte_ff <= 8'h00;
    soft_ff <= 1'b0;
    undef_ff <= 1'b0;
    ftrap_ff <= 1'b0;
    trst_ff <= 1'b0;
  end
  else if (ce_i)
  begin
    if (fetch_i)
      fbyte_ff <= (single_chip_i && addr_absent_i) ? `EITU_SOFT_OPCODE : mem_byte_i;
    soft_ff <= exec_i && (opcode_i == `EITU_SOFT_OPCODE) && !opcode_undef_i;
    undef_ff <= exec_i && opcode_undef_i;
    ftrap_ff <= bad_area && !trap_reset_sel_i;
    trst_ff <= bad_area && trap_reset_sel_i;
  end
end

assign fetch_byte_o = fbyte_ff;
assign soft_trap_o = soft_ff;
assign bad_opcode_trap_o = undef_ff;
assign fetch_trap_o = ftrap_ff;
assign trap_reset_o = trst_ff;
// Break current service, non-maskable included
assign abort_o = undef_ff | ftrap_ff;

////////////////////////////////////////////////////////////////////////
// Stack push on accept, pop on return

localparam ST_IDLE = 3'h0;
localparam ST_PUSH_PSW = 3'h1;
localparam ST_PUSH_PCH = 3'h2;
localparam ST_PUSH_PCL = 3'h3;
localparam ST_POP_PCL = 3'h4;
localparam ST_POP_PCH = 3'h5;
localparam ST_POP_PSW = 3'h6;

reg [2:0] st_ff;
reg [2:0] nxt_st;
reg [15:0] sp_ff;
reg [15:0] pc_ff;
reg [7:0] psw_ff;
reg [15:0] pcsave_ff;
reg [7:0] pswsave_ff;
reg done_ff;
reg [15:0] addr_r;
reg wr_r;
reg [7:0] wd_r;

always @*
begin
  nxt_st = st_ff;
  addr_r = sp_ff;
  wr_r = 1'b0;
  wd_r = 8'h00;
  case (st_ff)
    ST_IDLE:
    begin
      if (accept_i)
        nxt_st = ST_PUSH_PSW;
      else if (ret_i)
        nxt_st = ST_POP_PCL;
    end
    ST_PUSH_PSW:
    begin
      wr_r = 1'b1;
      wd_r = pswsave_ff;
      nxt_st = ST_PUSH_PCH;
    end
    ST_PUSH_PCH:
    begin
      addr_r = sp_ff - 16'h0001;
      wr_r = 1'b1;
      wd_r = pcsave_ff[15:8];
      nxt_st = ST_PUSH_PCL;
    end
    ST_PUSH_PCL:
    begin
      addr_r = sp_ff - 16'h0002;
      wr_r = 1'b1;
      wd_r = pcsave_ff[7:0];
      nxt_st = ST_IDLE;
    end
    ST_POP_PCL:
    begin
      addr_r = sp_ff + 16'h0001;
      nxt_st = ST_POP_PCH;
    end
    ST_POP_PCH:
    begin
      addr_r = sp_ff + 16'h0002;
      nxt_st = ST_POP_PSW;
    end
    ST_POP_PSW:
    begin
      addr_r = sp_ff + `EITU_RET_STEP;
      nxt_st = ST_IDLE;
    end
    default: nxt_st = ST_IDLE;
  endcase
end

always @(posedge clk_i or negedge rstn_i)
begin
  if (!rstn_i)
  begin
    st_ff <= ST_IDLE;
    sp_ff <= 16'h0000;
    pc_ff <= 16'h0000;
    psw_ff <= 8'h00;
    pcsave_ff <= 16'h0000;
    pswsave_ff <= 8'h00;
    done_ff <= 1'b0;
  end
  else if (ce_i)
  begin
    st_ff <= nxt_st;
    done_ff <= (st_ff == ST_POP_PSW);
    if (st_ff == ST_IDLE && accept_i)
    begin
      pcsave_ff <= pc_i;
      pswsave_ff <= status_word_i;
    end
    if (st_ff == ST_POP_PCL)
      pc_ff[7:0] <= mem_byte_i;
    if (st_ff == ST_POP_PCH)
      pc_ff[15:8] <= mem_byte_i;
    if (st_ff == ST_POP_PSW)
    begin
      psw_ff <= mem_byte_i;
      sp_ff <= sp_ff + `EITU_RET_STEP;
    end
    else if (st_ff == ST_PUSH_PCL)
      sp_ff <= sp_ff - `EITU_RET_STEP;
    else if (sp_load_i && st_ff == ST_IDLE)
      sp_ff <= sp_wdata_i;
  end
end

assign sp_o = sp_ff;
assign stack_addr_o = addr_r;
assign stack_wr_o = wr_r & ce_i;
assign stack_wdata_o = wd_r;
assign pc_o = pc_ff;
assign status_word_o = psw_ff;
assign master_irq_enable_o = psw_ff[7];
assign restore_o = done_ff;

endmodule // eitu_core

// ==== inc/eitu_regs.vh ====
// Constants for the external interrupt and trap unit
// What this block does
// - Return pops PC and status, SP plus 3
// - Saved PC low at SP+1, high SP+2
// - Requests sampled in instruction's last cycle
// - Trap opcode starts highest priority soft trap
// - Missing address fetch in single-chip returns FFH
// - Fetch from RAM, buffer, SFR traps
// - Watchdog bit picks reset or fetch trap
// - Undefined opcode trap accepted at once, aborts
// - Fetch trap accepted during non-maskable service
// - Six external lines, each noise filtered
// - Pin 0 is port after reset
// - Line 0 falling, latch blocked when unselected
// - Enables gate lines 0-5, slot selects gate lines 2-5
// - Lines 0,5 reject 2, accept 7 cycles
// - Line 1 filter 63/193 or 15/49
// - Lines 2-4 reject 7, accept 25 cycles
// - Slow modes reject 1, accept 3.5 cycles
// - Clean edge sets latch within 6 slow cycles
// - Line 4 select: rise, fall, both, high
// - Lines 1-3 select: 0 rise, 1 fall
// - Line 1 filter change within 26 cycles
// - Line 4 high at reset needs rising edge
// - Slot select routes line, unselected never latches
`ifndef EITU_REGS_VH
`define EITU_REGS_VH
`define EITU_CTRL_ADDR 6'h37
`define EITU_CTRL_RESET 8'h00
`define EITU_BIT_L1NC 7
`define EITU_BIT_P0SEL 6
`define EITU_BIT_L4ES_HI 5
`define EITU_BIT_L4ES_LO 4
`define EITU_BIT_L3ES 3
`define EITU_BIT_L2ES 2
`define EITU_BIT_L1ES 1
`define EITU_ES_RISE 2'h0
`define EITU_ES_FALL 2'h1
`define EITU_ES_BOTH 2'h2
`define EITU_ES_HIGH 2'h3
`define EITU_SOFT_OPCODE 8'hFF
`define EITU_RET_STEP 16'h0003
`define EITU_ACC_L05 8'h07
`define EITU_ACC_L1_SLOW_NC 8'hC1
`define EITU_ACC_L1_FAST_NC 8'h31
`define EITU_ACC_L234 8'h19
`define EITU_ACC_SLOWCLK 8'h04
`define EITU_SFR_LO 16'h0000
`define EITU_SFR_HI 16'h003F
`define EITU_DBR_LO 16'h0F80
`define EITU_DBR_HI 16'h0FFF
`define EITU_RAM_LO 16'h0040
`endif
